// ==== common/rbx_pkg.sv ====
// package for the return and bit-field execution block
package rbx_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_SP = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_OPER = 8'h14;
  localparam logic [7:0] ADDR_ST0 = 8'h18;
  localparam logic [7:0] ADDR_ST1 = 8'h1C;
  localparam logic [7:0] ADDR_STK_ADDR = 8'h20;
  localparam logic [7:0] ADDR_STK_DATA = 8'h24;
  localparam logic [7:0] ADDR_ACC_EXT = 8'h28;
  localparam logic [7:0] ADDR_ACC_LO = 8'h30;
  // ----------------------------------------
  // status word fields and reset values
  // ----------------------------------------
  localparam int ST_Z = 15;
  localparam int ST_M = 14;
  localparam int ST_C = 11;
  localparam int ST_IE = 7;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [35:0] ROUND_CONST = 36'h000008000;
  localparam logic [1:0] SLOT_CYCLES = 2'h2;
  localparam logic [1:0] CYC_RETI_TAKEN = 2'h3;
  localparam logic [1:0] CYC_RETI_SKIP = 2'h2;
  localparam logic [1:0] CYC_RETS = 2'h3;
  localparam logic [1:0] CYC_BITFIELD = 2'h2;
  localparam logic [1:0] IRQ_SRC_NMI = 2'h3;
  // ----------------------------------------
  // command encoding
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_RET, OP_RETD, OP_RETI, OP_RETID, OP_RETS,
    OP_RND, OP_ROL, OP_ROR, OP_BCLR, OP_BSET
  } rbx_op_t;
  typedef enum logic [1:0] {TGT_MEM, TGT_ST0, TGT_ST1, TGT_ACC} rbx_tgt_t;
  typedef enum logic [1:0] {CND_TRUE, CND_ZS, CND_ZC, CND_CS} rbx_cond_t;
  typedef struct packed {
    logic [7:0] imm;
    logic [1:0] irq_src;
    logic part_hi;
    logic [1:0] acc;
    rbx_tgt_t tgt;
    logic ctx;
    rbx_cond_t cond;
    logic [3:0] op;
  } rbx_cmd_t;
endpackage

// ==== verilog/rbx_exec.sv ====
// return and bit-field execution unit with apb register access
//
// Contract
// RL1 - conditional return pops pc, sp plus one
// RL2 - delayed return pops to temp, pc after slot
// RL3 - no interrupts during delayed return window
// RL4 - software keeps pipeline breakers out of slots
// RL5 - software avoids sp writes before delayed return
// RL6 - interrupt return pops pc, sets enable if maskable
// RL7 - interrupt return: 2 cycles skipped, 3 taken
// RL8 - context field swaps shadow context on return
// RL9 - delayed interrupt return pops, sets enable, slot
// RL10 - delayed interrupt return loads pc from temp
// RL11 - parameter-drop return: sp plus one plus imm
// RL12 - parameter-drop return leaves interrupt enable alone
// RL13 - rounding adds 0x8000 to a accumulator
// RL14 - rotates move accumulator through carry by one
// RL15 - bit clear ands operand with inverted mask
// RL16 - bit set ors operand with mask
// RL17 - only addressed accumulator part may change
// RL18 - status word 0 takes masked result directly
// RL19 - status word 1 flags follow alu output
// RL20 - other targets update only zero and minus
// RL21 - software never targets accumulators, product, pc; the bench targets accumulator halves through TGT_ACC
`timescale 1ns/10ps
module rbx_exec
  import rbx_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core status
  output logic [15:0] o_pc,
  output logic [15:0] o_sp,
  output logic o_global_irq_enable,
  output logic o_irq_block,
  output logic o_busy
);
  localparam int AW = $clog2(STACK_DEPTH);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] pc, next_pc, sp, next_sp, tmp, next_tmp;
  logic [15:0] mask, next_mask, oper, next_oper, stk_addr, next_stk_addr;
  logic [11:0] st0_hi, next_st0_hi, st1_hi, next_st1_hi, sh_st1_hi, next_sh_st1_hi;
  logic [35:0] acc [4];
  logic [35:0] next_acc [4];
  logic [35:0] sh_a0, next_sh_a0;
  logic [1:0] slot, next_slot, busy, next_busy;
  logic [31:0] prdata, next_prdata;
  logic [15:0] stk [STACK_DEPTH];

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  rbx_cmd_t cmd;
  rbx_op_t op;
  logic wr, hit, acc_go, cond_ok, stk_we;
  logic [15:0] st0, st1, pop, src, res, st0w, st1w;
  logic [1:0] cyc, dec;
  logic [31:0] rd_val;
  logic st0_full, st1_full;

  assign cmd = rbx_cmd_t'(i_pwdata[21:0]);
  assign op = rbx_op_t'(cmd.op);
  assign wr = i_psel && i_penable && i_pwrite;
  assign st0 = {st0_hi, acc[0][35:32]};
  assign st1 = {st1_hi, acc[1][35:32]};
  assign pop = stk[sp[AW-1:0]];
  // a command arriving while the unit is busy is dropped
  assign acc_go = wr && (i_paddr == ADDR_CMD) && (busy == 2'h0);
  assign stk_we = wr && (i_paddr == ADDR_STK_DATA);

  always_comb begin
    unique case (cmd.cond)
      CND_TRUE: cond_ok = 1'b1;
      CND_ZS: cond_ok = st0[ST_Z];
      CND_ZC: cond_ok = !st0[ST_Z];
      CND_CS: cond_ok = st0[ST_C];
    endcase
  end

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h00000000;
    unique case (i_paddr)
      ADDR_CMD: rd_val = 32'h00000000;
      ADDR_MASK: rd_val = {16'h0000, mask};
      ADDR_PC: rd_val = {16'h0000, pc};
      ADDR_SP: rd_val = {16'h0000, sp};
      ADDR_STAT: rd_val = {28'h0000000, (busy != 2'h0), o_irq_block, slot};
      ADDR_OPER: rd_val = {16'h0000, oper};
      ADDR_ST0: rd_val = {16'h0000, st0};
      ADDR_ST1: rd_val = {16'h0000, st1};
      ADDR_STK_ADDR: rd_val = {16'h0000, stk_addr};
      ADDR_STK_DATA: rd_val = {16'h0000, stk[stk_addr[AW-1:0]]};
      ADDR_ACC_EXT: rd_val = {16'h0000, acc[3][35:32], acc[2][35:32],
                              acc[1][35:32], acc[0][35:32]};
      8'h30, 8'h34, 8'h38, 8'h3C: rd_val = acc[i_paddr[3:2]][31:0];
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_pc = pc;
    next_sp = sp;
    next_tmp = tmp;
    next_mask = mask;
    next_oper = oper;
    next_stk_addr = stk_addr;
    next_sh_st1_hi = sh_st1_hi;
    next_sh_a0 = sh_a0;
    next_acc = acc;
    next_slot = slot;
    st0w = st0;
    st1w = st1;
    st0_full = 1'b0;
    st1_full = 1'b0;
    cyc = 2'h1;
    dec = 2'h0;
    src = 16'h0000;
    res = 16'h0000;
    next_prdata = prdata;
    if (i_psel && !i_penable) begin
      next_prdata = rd_val;
    end
    if (wr) begin
      unique case (i_paddr)
        ADDR_MASK: next_mask = i_pwdata[15:0];
        ADDR_PC: next_pc = i_pwdata[15:0];
        ADDR_SP: next_sp = i_pwdata[15:0];
        ADDR_OPER: next_oper = i_pwdata[15:0];
        ADDR_STK_ADDR: next_stk_addr = i_pwdata[15:0];
        ADDR_ST0: begin
          st0w = i_pwdata[15:0];
          st0_full = 1'b1;
        end
        ADDR_ST1: begin
          st1w = i_pwdata[15:0];
          st1_full = 1'b1;
        end
        ADDR_ACC_EXT: begin
          for (int i = 0; i < 4; i++) begin
            next_acc[i][35:32] = i_pwdata[4*i +: 4];
          end
        end
        8'h30, 8'h34, 8'h38, 8'h3C: next_acc[i_paddr[3:2]][31:0] = i_pwdata;
        default: ;
      endcase
    end
    if (acc_go) begin
      unique case (op)
        OP_RETI: cyc = cond_ok ? CYC_RETI_TAKEN : CYC_RETI_SKIP; // RL7
        OP_RETS: cyc = CYC_RETS;
        OP_BCLR, OP_BSET: cyc = CYC_BITFIELD;
        default: cyc = 2'h1;
      endcase
      // delay slot counts instruction cycles, then the saved pc lands
      if (slot != 2'h0) begin
        dec = (cyc > slot) ? slot : cyc;
        next_slot = slot - dec;
        if (next_slot == 2'h0) begin
          next_pc = tmp; // RL2 RL10
        end
      end
      unique case (op)
        OP_RET: begin
          if (cond_ok) begin
            next_pc = pop; // RL1
            next_sp = sp + 16'h0001;
          end
        end
        OP_RETD, OP_RETID: begin
          next_tmp = pop; // RL2 RL9
          next_sp = sp + 16'h0001;
          next_slot = SLOT_CYCLES; // RL3
          if (op == OP_RETID) begin
            st0w[ST_IE] = 1'b1; // RL9
          end
        end
        OP_RETI: begin
          if (cond_ok) begin
            next_tmp = pop; // RL6
            next_pc = pop;
            next_sp = sp + 16'h0001;
            if (cmd.irq_src != IRQ_SRC_NMI) begin
              st0w[ST_IE] = 1'b1; // RL6
            end
            if (cmd.ctx) begin
              next_sh_a0 = acc[0]; // RL8
              next_acc[0] = sh_a0;
              next_sh_st1_hi = st1_hi;
              st1w[15:4] = sh_st1_hi;
            end
          end
        end
        OP_RETS: begin
          next_pc = pop; // RL11 RL12
          next_sp = sp + 16'h0001 + {8'h00, cmd.imm};
        end
        OP_RND: begin
          if (cond_ok) begin
            next_acc[{1'b0, cmd.acc[0]}] = acc[{1'b0, cmd.acc[0]}] + ROUND_CONST; // RL13
          end
        end
        OP_ROL: begin
          if (cond_ok) begin
            next_acc[cmd.acc] = {acc[cmd.acc][34:0], st0[ST_C]}; // RL14
            st0w[ST_C] = acc[cmd.acc][35];
          end
        end
        OP_ROR: begin
          if (cond_ok) begin
            next_acc[cmd.acc] = {st0[ST_C], acc[cmd.acc][35:1]}; // RL14
            st0w[ST_C] = acc[cmd.acc][0];
          end
        end
        OP_BCLR, OP_BSET: begin
          unique case (cmd.tgt)
            TGT_MEM: src = oper;
            TGT_ST0: src = st0;
            TGT_ST1: src = st1;
            TGT_ACC: src = cmd.part_hi ? acc[cmd.acc][31:16] : acc[cmd.acc][15:0];
          endcase
          res = (op == OP_BSET) ? (src | mask) : (src & ~mask); // RL15 RL16
          if (cmd.tgt == TGT_ST0) begin
            st0w = res; // RL18
            st0_full = 1'b1;
          end else begin
            st0w[ST_Z] = (res == 16'h0000); // RL20
            st0w[ST_M] = res[15];
            unique case (cmd.tgt)
              TGT_MEM: next_oper = res; // RL17
              TGT_ST1: begin
                st1w = res; // RL19
                st1_full = 1'b1;
              end
              TGT_ACC: begin
                if (cmd.part_hi) begin
                  next_acc[cmd.acc][31:16] = res; // RL17
                end else begin
                  next_acc[cmd.acc][15:0] = res;
                end
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    next_st0_hi = st0w[15:4];
    next_st1_hi = st1w[15:4];
    if (st0_full) begin
      next_acc[0][35:32] = st0w[3:0];
    end
    if (st1_full) begin
      next_acc[1][35:32] = st1w[3:0];
    end
    next_busy = (busy != 2'h0) ? busy - 2'h1 : (acc_go ? cyc - 2'h1 : 2'h0);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pc <= PC_RESET;
      sp <= SP_RESET;
      tmp <= 16'h0000;
      mask <= 16'h0000;
      oper <= 16'h0000;
      stk_addr <= 16'h0000;
      st0_hi <= 12'h000;
      st1_hi <= 12'h000;
      sh_st1_hi <= 12'h000;
      sh_a0 <= 36'h000000000;
      for (int i = 0; i < 4; i++) begin
        acc[i] <= 36'h000000000;
      end
      slot <= 2'h0;
      busy <= 2'h0;
      prdata <= 32'h00000000;
    end else begin
      pc <= next_pc;
      sp <= next_sp;
      tmp <= next_tmp;
      mask <= next_mask;
      oper <= next_oper;
      stk_addr <= next_stk_addr;
      st0_hi <= next_st0_hi;
      st1_hi <= next_st1_hi;
      sh_st1_hi <= next_sh_st1_hi;
      sh_a0 <= next_sh_a0;
      acc <= next_acc;
      slot <= next_slot;
      busy <= next_busy;
      prdata <= next_prdata;
    end
  end

  // stack ram has no reset: contents are loaded by software
  always_ff @(posedge i_mclk) begin
    if (stk_we) begin
      stk[stk_addr[AW-1:0]] <= i_pwdata[15:0];
    end
  end

  assign o_prdata = prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_pc = pc;
  assign o_sp = sp;
  assign o_global_irq_enable = st0[ST_IE];
  assign o_irq_block = (slot != 2'h0);
  assign o_busy = (busy != 2'h0);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [35:0] a0_now;
  assign a0_now = acc[0];

  sequence s_busy_two;
    o_busy ##1 o_busy ##1 !o_busy;
  endsequence
  property p_ret;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RET && cond_ok |=> pc == $past(pop) && sp == $past(sp) + 16'h0001;
  endproperty
  a_ret: assert property (p_ret) else $error("ret pop wrong"); // RL1
  property p_retd;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RETD |=> sp == $past(sp) + 16'h0001 && tmp == $past(pop) && o_irq_block;
  endproperty
  a_retd: assert property (p_retd) else $error("retd pop wrong"); // RL2 RL3
  property p_slot_end;
    @(posedge i_mclk) disable iff (i_reset)
    slot != 2'h0 && next_slot == 2'h0 |=> pc == $past(tmp);
  endproperty
  a_slot_end: assert property (p_slot_end) else $error("slot pc not loaded"); // RL10
  property p_reti_ie;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RETI && cond_ok && cmd.irq_src != IRQ_SRC_NMI |=> o_global_irq_enable;
  endproperty
  a_reti_ie: assert property (p_reti_ie) else $error("reti enable not set"); // RL6
  property p_reti_cyc;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RETI && cond_ok |=> s_busy_two;
  endproperty
  a_reti_cyc: assert property (p_reti_cyc) else $error("reti not 3 cycles"); // RL7
  property p_rets;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RETS |=> sp == $past(sp) + 16'h0001 + {8'h00, $past(cmd.imm)}
      && o_global_irq_enable == $past(o_global_irq_enable);
  endproperty
  a_rets: assert property (p_rets) else $error("rets wrong"); // RL11 RL12
  property p_rnd;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_RND && cond_ok && cmd.acc[0] == 1'b0 |=> a0_now == $past(a0_now) + ROUND_CONST;
  endproperty
  a_rnd: assert property (p_rnd) else $error("round wrong"); // RL13
  property p_bclr;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_BCLR && cmd.tgt == TGT_MEM |=> oper == ($past(oper) & ~$past(mask))
      && a0_now == $past(a0_now);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong"); // RL15 RL17
  property p_bset_st0;
    @(posedge i_mclk) disable iff (i_reset)
    acc_go && op == OP_BSET && cmd.tgt == TGT_ST0 |=> st0 == ($past(st0) | $past(mask));
  endproperty
  a_bset_st0: assert property (p_bset_st0) else $error("st0 set wrong"); // RL16 RL18
endmodule

// ==== test/rbx_prog.sv ====
// program-side model: supplies legal filler instructions for delay slots
`timescale 1ns/10ps
module rbx_prog
  import rbx_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // next filler instruction
  output rbx_cmd_t o_slot_cmd
);
  rbx_cmd_t c;
  always @(posedge i_mclk) begin
    c = '0;
    // only single-cycle rnd/rol/ror: no branch, trap, repeat or pc write
    c.op = 4'(OP_RND) + 4'($urandom_range(2));
    // never a whole accumulator, product or pc as bit-field target
    c.tgt = TGT_MEM;
    c.acc = 2'($urandom_range(3));
    if (c.op == OP_RND) c.acc[1] = 1'b0;
    o_slot_cmd <= i_reset ? '0 : c;
  end
endmodule

// ==== test/rbx_exec_test.sv ====
// self-checking bench for the return and bit-field execution unit
`timescale 1ns/10ps
module rbx_exec_test;
  import rbx_pkg::*;
  logic i_mclk, i_reset, i_psel, i_penable, i_pwrite, err;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_global_irq_enable, o_irq_block, o_busy;
  logic [15:0] o_pc, o_sp;
  rbx_cmd_t slot_cmd;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  rbx_exec rbx_exec_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pc(o_pc),
    .o_sp(o_sp), .o_global_irq_enable(o_global_irq_enable), .o_irq_block(o_irq_block),
    .o_busy(o_busy));
  rbx_prog rbx_prog_i (.i_mclk(i_mclk), .i_reset(i_reset), .o_slot_cmd(slot_cmd));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  // issue one command, then count the cycles it keeps the unit busy
  task automatic cmd(input logic [21:0] c, output int nb);
    wr(ADDR_CMD, 32'(c));
    nb = 0;
    #1;
    while (o_busy === 1'b1) begin
      @(posedge i_mclk);
      #1;
      nb++;
    end
  endtask
  task automatic top(input logic [15:0] sp, input logic [15:0] w);
    wr(ADDR_SP, 32'(sp));
    wr(ADDR_STK_ADDR, 32'(sp));
    wr(ADDR_STK_DATA, 32'(w));
  endtask
  function automatic logic [21:0] mk(input logic [3:0] op, input logic [1:0] cd,
      input logic [1:0] t, input logic [1:0] k, input logic hi, input logic [1:0] src,
      input logic [7:0] imm);
    return {imm, src, hi, k, t, 1'b0, cd, op};
  endfunction
  function automatic logic cnd_ok(input logic [15:0] s, input logic [1:0] cd);
    return cd == 2'h0 || (cd == 2'h1 && s[ST_Z]) || (cd == 2'h2 && !s[ST_Z])
      || (cd == 2'h3 && s[ST_C]);
  endfunction
  // returns {carry, accumulator}
  function automatic logic [36:0] alu(input int o, input logic [35:0] a, input logic c);
    if (o == 0) return {c, a + ROUND_CONST};
    if (o == 1) return {a, c};
    return {a[0], c, a[35:1]};
  endfunction
  function automatic logic [15:0] bf(input logic set, input logic [15:0] v, input logic [15:0] m);
    return set ? (v | m) : (v & ~m);
  endfunction
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] s, sp, w, m, v;
    logic [31:0] q, q2, sq;
    logic [35:0] a, e;
    logic [36:0] r;
    logic [1:0] k;
    logic [7:0] ad;
    logic ok;
    int nb;
    i_reset = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = '0;
    i_pwdata = '0;
    q = $urandom(32'h38727C15);
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    chk("pc rst", PC_RESET, o_pc);
    chk("sp rst", SP_RESET, o_sp);
    chk("ie rst", 1'b0, o_global_irq_enable);
    apb(1'b0, 8'h2C, 32'h0, q);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      s = 16'($urandom);
      sp = 16'($urandom);
      w = 16'($urandom);
      wr(ADDR_ST0, 32'(s));
      top(sp, w);
      v = o_pc;
      ok = cnd_ok(s, 2'(i % 4));
      cmd(mk(OP_RET, 2'(i % 4), 2'h0, 2'h0, 1'b0, 2'h0, 8'h0), nb);
      chk("ret pc", ok ? w : v, o_pc);
      chk("ret sp", ok ? 16'(sp + 16'h1) : sp, o_sp);
    end
    for (int i = 0; i < 8; i++) begin
      s = 16'($urandom) & 16'hFF7F;
      sp = 16'($urandom);
      w = 16'($urandom);
      wr(ADDR_ST0, 32'(s));
      top(sp, w);
      v = o_pc;
      k = (i < 4) ? 2'h0 : 2'($urandom);
      ok = cnd_ok(s, k);
      cmd(mk(OP_RETI, k, 2'h0, 2'h0, 1'b0, 2'(i % 4), 8'h0) | {15'h0, i == 3, 6'h00}, nb);
      chk("reti busy", ok ? 2 : 1, nb);
      chk("reti pc", ok ? w : v, o_pc);
      chk("reti sp", ok ? 16'(sp + 16'h1) : sp, o_sp);
      chk("reti ie", ok && i % 4 != 3, o_global_irq_enable);
      apb(1'b0, ADDR_ST0, 32'h0, sq);
      // shadow is still zero at the first swap, so the a0 extension must clear
      chk("reti ctx", (i == 3) ? 4'h0 : s[3:0], sq[3:0]);
    end
    for (int i = 0; i < 4; i++) begin
      s = 16'($urandom);
      sp = 16'($urandom);
      w = 16'($urandom);
      m = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00FF : 16'($urandom_range(255));
      wr(ADDR_ST0, 32'(s));
      top(sp, w);
      cmd(mk(OP_RETS, 2'h0, 2'h0, 2'h0, 1'b0, 2'h0, m[7:0]), nb);
      chk("rets busy", 2, nb);
      chk("rets pc", w, o_pc);
      chk("rets sp", 16'(sp + 16'h1 + m), o_sp);
      chk("rets ie", s[ST_IE], o_global_irq_enable);
    end
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_ST0, 32'h0);
      v = 16'($urandom);
      wr(ADDR_PC, 32'(v));
      sp = 16'($urandom);
      w = 16'($urandom);
      top(sp, w);
      cmd(mk(i ? OP_RETID : OP_RETD, 2'h0, 2'h0, 2'h0, 1'b0, 2'h0, 8'h0), nb);
      chk("delayed sp", 16'(sp + 16'h1), o_sp);
      chk("delayed pc", v, o_pc);
      chk("delayed block", 1'b1, o_irq_block);
      chk("delayed ie", i[0], o_global_irq_enable);
      if (i == 0) begin
        cmd(22'(slot_cmd), nb);
        chk("slot pc", v, o_pc);
        chk("slot block", 1'b1, o_irq_block);
        cmd(22'(slot_cmd), nb);
      end else begin
        cmd(mk(OP_BSET, 2'h0, 2'h0, 2'h0, 1'b0, 2'h0, 8'h0), nb);
      end
      chk("return pc", w, o_pc);
      chk("block end", 1'b0, o_irq_block);
    end
    for (int i = 0; i < 9; i++) begin
      k = 2'($urandom);
      if (i % 3 == 0) k[1] = 1'b0;
      a = {4'($urandom), 32'($urandom)};
      s = 16'($urandom);
      ad = ADDR_ACC_LO + 8'(4 * k);
      wr(ADDR_ST0, 32'(s));
      wr(ADDR_ACC_EXT, 32'(a[35:32]) << (4 * k));
      wr(ad, a[31:0]);
      cmd(mk(4'(OP_RND) + 4'(i % 3), 2'h0, 2'h0, k, 1'b0, 2'h0, 8'h0), nb);
      apb(1'b0, ad, 32'h0, q);
      apb(1'b0, ADDR_ACC_EXT, 32'h0, q2);
      apb(1'b0, ADDR_ST0, 32'h0, sq);
      r = alu(i % 3, a, s[ST_C]);
      chk("acc", r[35:0], {q2[4 * k +: 4], q});
      if (i % 3 != 0) chk("carry", r[36], sq[ST_C]);
    end
    for (int i = 0; i < 12; i++) begin
      s = 16'($urandom);
      v = 16'($urandom);
      m = (i < 6) ? 16'($urandom) : 16'hFFFF;
      ad = (i / 2 % 3 == 0) ? ADDR_OPER : (i / 2 % 3 == 1) ? ADDR_ST0 : ADDR_ST1;
      wr(ADDR_ST0, 32'(s));
      if (ad != ADDR_ST0) wr(ad, 32'(v));
      else v = s;
      wr(ADDR_MASK, 32'(m));
      cmd(mk(4'(OP_BCLR) + 4'(i % 2), 2'h0, 2'(i / 2 % 3), 2'h0, 1'b0, 2'h0, 8'h0), nb);
      apb(1'b0, ad, 32'h0, q);
      apb(1'b0, ADDR_ST0, 32'h0, sq);
      w = bf(i[0], v, m);
      chk("field", w, q[15:0]);
      if (ad == ADDR_OPER) chk("flags", {w == 16'h0, w[15], s[13:0]}, sq[15:0]);
    end
    for (int i = 0; i < 8; i++) begin
      k = 2'(i % 4);
      a = {4'($urandom), 32'($urandom)};
      m = 16'($urandom);
      ad = ADDR_ACC_LO + 8'(4 * k);
      wr(ADDR_ACC_EXT, 32'(a[35:32]) << (4 * k));
      wr(ad, a[31:0]);
      wr(ADDR_MASK, 32'(m));
      cmd(mk(4'(OP_BCLR) + 4'(i % 2), 2'h0, 2'(TGT_ACC), k, 1'(i / 4), 2'h0, 8'h0), nb);
      apb(1'b0, ad, 32'h0, q);
      apb(1'b0, ADDR_ACC_EXT, 32'h0, q2);
      e = (i / 4) ? {a[35:32], bf(i[0], a[31:16], m), a[15:0]}
                  : {a[35:16], bf(i[0], a[15:0], m)};
      chk("acc part", e, {q2[4 * k +: 4], q});
    end
    finish_test();
  end
endmodule
